// file: pkg/sbc_regs.svh
// Constants of the SPI byte controller
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// ****************************************
// Sizes and counts
// ****************************************
`define SBC_LAST_EDGE   5'h0F
`define SBC_ALL_SAMPLES 4'h8
`define SBC_LAST_SAMPLE 4'h7
`define SBC_BUF_DEPTH   2

// ****************************************
// Status bit positions
// ****************************************
`define SBC_ST_ABORT      3
`define SBC_ST_MODE_FAULT 4
`define SBC_ST_OVERRUN    5
`define SBC_ST_COLLIDE    6
`define SBC_ST_DONE       7

// ****************************************
// Reset values
// ****************************************
`define SBC_RST_BYTE 8'h00
`define SBC_SYNC_RST 4'h8

`endif

// file: pkg/sbc_pkg.sv
// Types of the SPI byte controller
`default_nettype none
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_IDLE = 2'h0,
        SBC_RUN  = 2'h1,
        SBC_FIN  = 2'h3
    } sbc_state_type;
    typedef logic [7:0] sbc_byte_type;
endpackage : sbc_pkg
`default_nettype wire

// file: pkg/sbc_strm_if.sv
// Byte stream with valid and ready between controller and receive buffer
`timescale 1ns/10ps
`default_nettype none
interface sbc_strm_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sbc_strm_if
`default_nettype wire

// file: hw/sbc_rx_buf.sv
// Two-entry receive byte buffer, head entry always at index 0
`timescale 1ns/10ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_rx_buf
    import sbc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    sbc_strm_if.snk   in_s,
    sbc_strm_if.src   out_s
);
    localparam int DEPTH = `SBC_BUF_DEPTH;

    sbc_byte_type     mem_r [DEPTH];
    logic [DEPTH-1:0] vld_r;
    logic [DEPTH-1:0] sh_w;
    logic [DEPTH-1:0] wr_w;
    logic             pop_w;
    logic             push_w;

    assign pop_w       = vld_r[0] && out_s.ready;
    assign in_s.ready  = !vld_r[DEPTH-1];
    assign push_w      = in_s.valid && in_s.ready;
    assign sh_w        = pop_w ? (vld_r >> 1) : vld_r;
    assign out_s.valid = vld_r[0];
    assign out_s.data  = mem_r[0];

    // ****************************************
    // Entries
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            sbc_byte_type up_w;
            logic         low_w;
            if (gi == DEPTH-1) begin : g_top
                assign up_w = `SBC_RST_BYTE;
            end else begin : g_mid
                assign up_w = mem_r[gi+1];
            end
            if (gi == 0) begin : g_first
                assign low_w = 1'b1;
            end else begin : g_next
                assign low_w = sh_w[gi-1];
            end
            assign wr_w[gi] = push_w && !sh_w[gi] && low_w;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    vld_r[gi] <= 1'b0;
                    mem_r[gi] <= `SBC_RST_BYTE;
                end else begin
                    vld_r[gi] <= sh_w[gi] | wr_w[gi];
                    mem_r[gi] <= wr_w[gi] ? in_s.data : (pop_w ? up_w : mem_r[gi]);
                end
            end
        end
    endgenerate
endmodule : sbc_rx_buf
`default_nettype wire

// file: hw/sbc_spi_ctrl.sv
// SPI byte controller: master/slave shifter, status flags and pin drivers
`timescale 1ns/10ps
`default_nettype none
`include "sbc_regs.svh"
// Functional notes
// - Each transfer swaps exactly one 8-bit byte in both directions.
// - Polarity 0 phase 0: first bit before first rise, shift on fall, sample on rise.
// - Polarity 0 phase 1: drive on rising edges, sample on falling edges.
// - Polarity 1 phase 0: first bit before first fall, shift on rise, sample on fall.
// - Polarity 1 phase 1: drive on falling edges, sample on rising edges.
// - Master starts clocking when a byte is written and the receive stream buffer has room, ends after last clock cycle.
// - Slave with phase 0: transfer spans the active select period.
// - Slave with phase 1: transfer spans first edge to last sampling edge.
// - Data writes load the shift register directly, no transmit buffer.
// - Finished byte goes to a one-byte receive buffer, which data reads return.
// - Clock divider acts only in master mode.
// - In master mode a data write starts a transfer.
// - Done flag sets after final master cycle or last slave sampling edge.
// - Done flag clears by status read followed by a data access.
// - Slave drives its output only while selected; push-pull only.
// - Completion while done flag set keeps the old byte for data reads, offers the new one to the stream buffer, sets overrun.
// - Writes from transfer start until status read after done are dropped, flagged.
// - Select active while master sets mode fault, drivers off, becomes slave.
// - Deselect before slave completion drops the byte and sets abort flag.
// - Slave select is active low.
// - With interrupt enable, done or collision sets sticky interrupt; write 1 clears.
module sbc_spi_ctrl
    import sbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       master_en,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb_first,
    input  wire logic       interrupt_enable_bit,
    input  wire logic [7:0] clock_divider_register,
    input  wire logic       ctl_wr,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       data_rd,
    input  wire logic       status_rd,
    input  wire logic       int_clr,
    output logic      [7:0] rd_data,
    output logic      [7:0] status,
    output logic            interrupt_flag_register,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    input  wire logic       rx_ready,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe,
    input  wire logic       ssel_n
);
    localparam logic [3:0] SYNC_RST = `SBC_SYNC_RST;
    logic [3:0]    pin_w;
    logic [3:0]    s1_r;
    logic [3:0]    s2_r;
    logic          sck_d_r;
    sbc_state_type st_r;
    sbc_state_type st_nxt;
    logic [6:0]    hcnt_r;
    logic [6:0]    hcnt_nxt;
    logic [4:0]    ecnt_r;
    logic [4:0]    ecnt_nxt;
    logic [3:0]    nsamp_r;
    logic [3:0]    nsamp_nxt;
    logic [2:0]    txi_r;
    logic [2:0]    txi_nxt;
    logic          seen_r;
    logic          seen_nxt;
    sbc_byte_type  tx_r;
    sbc_byte_type  rx_r;
    sbc_byte_type  rx_nxt;
    sbc_byte_type  rxbuf_r;
    logic          go_r;
    logic          done_pend_r;
    logic          transfer_done_flag_r;
    logic          transfer_done_flag_arm_r;
    logic          read_overrun_flag_r;
    logic          write_collision_flag_r;
    logic          write_collision_flag_arm_r;
    logic          mode_fault_flag_r;
    logic          mode_fault_flag_arm_r;
    logic          slave_abort_flag_r;
    logic          int_r;
    logic          sck_o_r;
    logic          sck_o_nxt;
    logic          sck_oe_r;
    logic          mosi_o_r;
    logic          mosi_oe_r;
    logic          miso_o_r;
    logic          miso_oe_r;
    logic          ssel_s;
    logic          sck_s;
    logic          mosi_s;
    logic          miso_s;
    logic          mst;
    logic          sel;
    logic [7:0]    half_w;
    logic          m_tick;
    logic          s_edge;
    logic          edge_w;
    logic          lead_w;
    logic          samp_w;
    logic          drv_w;
    logic          din_w;
    logic          wrap_w;
    logic          last_samp;
    logic          cmpl;
    logic          outbit;
    logic          busy;
    logic          blocked;
    logic          wr_ok;
    logic          write_collision_flag_set;
    logic          start;
    logic          dacc;
    logic          transfer_done_flag_clr;
    logic          write_collision_flag_clr;
    logic          mode_fault_flag_set;
    logic          abort_ev;

    sbc_strm_if in_s ();
    sbc_strm_if out_s ();
    // ****************************************
    // Pin synchronisers
    // ****************************************
    assign pin_w = {ssel_n, sck_i, mosi_i, miso_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[gi] <= SYNC_RST[gi];
                    s2_r[gi] <= SYNC_RST[gi];
                end else begin
                    s1_r[gi] <= pin_w[gi];
                    s2_r[gi] <= s1_r[gi];
                end
            end
        end
    endgenerate
    assign ssel_s = s2_r[3];
    assign sck_s  = s2_r[2];
    assign mosi_s = s2_r[1];
    assign miso_s = s2_r[0];
    assign sel    = !ssel_s;
    assign mst    = master_en && !mode_fault_flag_r;

    // ****************************************
    // Master clock generation
    // ****************************************
    assign half_w    = {1'b0, clock_divider_register[7:1]};
    assign m_tick    = mst && (st_r == SBC_RUN) && (({1'b0, hcnt_r} + 8'h01) >= half_w);
    assign hcnt_nxt  = (!mst || st_r != SBC_RUN || m_tick) ? 7'h00 : 7'(hcnt_r + 7'h01);
    assign ecnt_nxt  = (st_r != SBC_RUN) ? 5'h00 : (m_tick ? 5'(ecnt_r + 5'h01) : ecnt_r);
    assign sck_o_nxt = (mst && st_r == SBC_RUN) ? (sck_o_r ^ m_tick) : cpol;
    assign start     = mst && (st_r == SBC_IDLE) && go_r && in_s.ready;

    always_comb begin
        case (st_r)
            SBC_IDLE: st_nxt = start ? SBC_RUN : SBC_IDLE;
            SBC_RUN:  st_nxt = !mst ? SBC_IDLE : ((m_tick && ecnt_r == `SBC_LAST_EDGE) ? SBC_FIN : SBC_RUN);
            SBC_FIN:  st_nxt = SBC_IDLE;
            default:  st_nxt = SBC_IDLE;
        endcase
    end

    // ****************************************
    // Edges, sampling and shifting
    // ****************************************
    assign s_edge    = !mst && sel && (sck_s != sck_d_r);
    assign edge_w    = mst ? m_tick : s_edge;
    assign lead_w    = mst ? !ecnt_r[0] : (sck_s != cpol);
    assign samp_w    = edge_w && (lead_w != cpha);
    assign drv_w     = edge_w && (lead_w == cpha);
    assign din_w     = mst ? miso_s : mosi_s;
    assign rx_nxt    = !samp_w ? rx_r : (lsb_first ? {din_w, rx_r[7:1]} : {rx_r[6:0], din_w});
    assign wrap_w    = mst ? (st_r == SBC_IDLE)
                           : (!sel || (nsamp_r == `SBC_ALL_SAMPLES && (cpha || drv_w)));
    assign nsamp_nxt = wrap_w ? 4'h0 : (samp_w ? 4'(nsamp_r + 4'h1) : nsamp_r);
    assign txi_nxt   = wrap_w ? 3'h0 : ((drv_w && seen_r) ? 3'(txi_r + 3'h1) : txi_r);
    assign seen_nxt  = !wrap_w && (seen_r || edge_w);
    assign last_samp = samp_w && (nsamp_r == `SBC_LAST_SAMPLE);
    assign cmpl      = (st_r == SBC_FIN) || done_pend_r;
    assign outbit    = lsb_first ? tx_r[txi_r] : tx_r[3'(3'h7 - txi_r)];

    // ****************************************
    // Software access and flags
    // ****************************************
    assign busy     = mst ? (st_r != SBC_IDLE || go_r) : (sel && (seen_r || !cpha));
    assign blocked  = busy || (transfer_done_flag_r && !transfer_done_flag_arm_r);
    assign wr_ok    = data_wr && !blocked;
    assign write_collision_flag_set = data_wr && blocked;
    assign dacc     = data_rd || data_wr;
    assign transfer_done_flag_clr = transfer_done_flag_arm_r && dacc;
    assign write_collision_flag_clr = write_collision_flag_arm_r && dacc;
    assign mode_fault_flag_set = mst && sel;
    assign abort_ev = !mst && !sel && seen_r && (nsamp_r != `SBC_ALL_SAMPLES);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= SBC_IDLE;
            hcnt_r      <= 7'h00;
            ecnt_r      <= 5'h00;
            nsamp_r     <= 4'h0;
            txi_r       <= 3'h0;
            seen_r      <= 1'b0;
            sck_d_r     <= 1'b0;
            rx_r        <= `SBC_RST_BYTE;
            done_pend_r <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            hcnt_r      <= hcnt_nxt;
            ecnt_r      <= ecnt_nxt;
            nsamp_r     <= nsamp_nxt;
            txi_r       <= txi_nxt;
            seen_r      <= seen_nxt;
            sck_d_r     <= sck_s;
            rx_r        <= rx_nxt;
            done_pend_r <= !mst && last_samp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r    <= `SBC_RST_BYTE;
            go_r    <= 1'b0;
            rxbuf_r <= `SBC_RST_BYTE;
        end else begin
            tx_r    <= wr_ok ? data_wdata : tx_r;
            go_r    <= mst && (wr_ok || (go_r && !start));
            rxbuf_r <= (cmpl && !transfer_done_flag_r) ? rx_r : rxbuf_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_done_flag_r   <= 1'b0;
            transfer_done_flag_arm_r             <= 1'b0;
            read_overrun_flag_r    <= 1'b0;
            write_collision_flag_r <= 1'b0;
            write_collision_flag_arm_r             <= 1'b0;
            mode_fault_flag_r      <= 1'b0;
            mode_fault_flag_arm_r             <= 1'b0;
            slave_abort_flag_r     <= 1'b0;
            int_r                  <= 1'b0;
        end else begin
            transfer_done_flag_r   <= cmpl || (transfer_done_flag_r && !transfer_done_flag_clr);
            transfer_done_flag_arm_r             <= !transfer_done_flag_clr && (transfer_done_flag_arm_r || (status_rd && transfer_done_flag_r));
            read_overrun_flag_r    <= (cmpl && transfer_done_flag_r) || (read_overrun_flag_r && !status_rd);
            write_collision_flag_r <= write_collision_flag_set || (write_collision_flag_r && !write_collision_flag_clr);
            write_collision_flag_arm_r             <= !write_collision_flag_clr && (write_collision_flag_arm_r || (status_rd && write_collision_flag_r));
            mode_fault_flag_r      <= mode_fault_flag_set || (mode_fault_flag_r && !(mode_fault_flag_arm_r && ctl_wr));
            mode_fault_flag_arm_r             <= !(mode_fault_flag_arm_r && ctl_wr) && (mode_fault_flag_arm_r || (status_rd && mode_fault_flag_r));
            slave_abort_flag_r     <= abort_ev || (slave_abort_flag_r && !status_rd);
            int_r                  <= (interrupt_enable_bit && (cmpl || write_collision_flag_set)) || (int_r && !int_clr);
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_o_r   <= 1'b0;
            sck_oe_r  <= 1'b0;
            mosi_o_r  <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_o_r  <= 1'b0;
            miso_oe_r <= 1'b0;
        end else begin
            sck_o_r   <= sck_o_nxt;
            sck_oe_r  <= mst;
            mosi_o_r  <= outbit;
            mosi_oe_r <= mst;
            miso_o_r  <= outbit;
            miso_oe_r <= !mst && sel;
        end
    end

    // ****************************************
    // Receive stream buffer
    // ****************************************
    assign in_s.valid  = cmpl;
    assign in_s.data   = rx_r;
    assign out_s.ready = rx_ready;

    sbc_rx_buf u_rx_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (in_s),
        .out_s (out_s)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data                     = rxbuf_r;
    assign status[2:0]                 = 3'h0;
    assign status[`SBC_ST_ABORT]       = slave_abort_flag_r;
    assign status[`SBC_ST_MODE_FAULT]  = mode_fault_flag_r;
    assign status[`SBC_ST_OVERRUN]     = read_overrun_flag_r;
    assign status[`SBC_ST_COLLIDE]     = write_collision_flag_r;
    assign status[`SBC_ST_DONE]        = transfer_done_flag_r;
    assign interrupt_flag_register     = int_r;
    assign rx_valid                    = out_s.valid;
    assign rx_data                     = out_s.data;
    assign sck_o                       = sck_o_r;
    assign sck_oe                      = sck_oe_r;
    assign mosi_o                      = mosi_o_r;
    assign mosi_oe                     = mosi_oe_r;
    assign miso_o                      = miso_o_r;
    assign miso_oe                     = miso_oe_r;

    // ****************************************
    // Assertions
    // ****************************************
    a_master_byte:
    assert property (@(posedge clk) disable iff (!rst_n) st_r == SBC_FIN |-> nsamp_r == 4'h8)
        else $error("Master byte ended without eight samples");
    a_master_start:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ok && mst && !sel && in_s.ready) |=> go_r ##1 (st_r == SBC_RUN))
        else $error("Master write did not start a transfer");
    a_done_set:
    assert property (@(posedge clk) disable iff (!rst_n) cmpl |=> transfer_done_flag_r)
        else $error("Done flag not set at completion");
    a_done_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
        (transfer_done_flag_r && !transfer_done_flag_arm_r) |=> transfer_done_flag_r)
        else $error("Done flag cleared without status read");
    a_overrun_drop:
    assert property (@(posedge clk) disable iff (!rst_n)
        (cmpl && transfer_done_flag_r) |=> read_overrun_flag_r && $stable(rxbuf_r))
        else $error("Overrun did not keep the buffer");
    a_collide_drop:
    assert property (@(posedge clk) disable iff (!rst_n) write_collision_flag_set |=> write_collision_flag_r && $stable(tx_r))
        else $error("Colliding write not dropped");
    a_fault_off:
    assert property (@(posedge clk) disable iff (!rst_n) mode_fault_flag_set |=> mode_fault_flag_r ##1 (!sck_oe_r && !mosi_oe_r))
        else $error("Mode fault left drivers on");
    a_slave_oe:
    assert property (@(posedge clk) disable iff (!rst_n) miso_oe_r |-> $past(sel) && !$past(mst))
        else $error("Slave output driven while deselected");
    a_abort_flag:
    assert property (@(posedge clk) disable iff (!rst_n) abort_ev |=> slave_abort_flag_r && !done_pend_r)
        else $error("Abort not flagged");
    a_idle_clock:
    assert property (@(posedge clk) disable iff (!rst_n)
        (mst && st_r == SBC_IDLE) [*2] |-> sck_o_r == $past(cpol))
        else $error("Idle master clock not at inactive level");
    a_slave_nodiv:
    assert property (@(posedge clk) disable iff (!rst_n) !mst |=> hcnt_r == 7'h00)
        else $error("Divider runs in slave mode");
    a_int_set:
    assert property (@(posedge clk) disable iff (!rst_n) (interrupt_enable_bit && cmpl) |=> int_r)
        else $error("Interrupt flag not set");
endmodule : sbc_spi_ctrl
`default_nettype wire

// file: verif/sbc_spi_peer.sv
// External SPI slave model facing the controller in master mode
`timescale 1ns/10ps
`default_nettype none
module sbc_spi_peer (
    input  wire logic       sck,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsbf,
    input  wire logic       sel,
    input  wire logic       mosi,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic      [7:0] rx
);
    int n = 0;
    function automatic int ix(input int k);
        return lsbf ? k : 7 - k;
    endfunction : ix
    initial miso = 1'b0;
    always @(posedge sel) begin
        n = 0;
        miso = cpha ? ~tx[ix(0)] : tx[ix(0)];
    end
    always @(negedge sel) miso = ~miso;
    always @(sck) begin
        if (sel && ((sck !== cpol) ^ cpha)) begin
            rx[ix(n)] = mosi;
            n = n + 1;
        end else if (sel) begin
            miso = (n < 8) ? tx[ix(n)] : ~miso;
        end
    end
endmodule : sbc_spi_peer
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the SPI byte controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, master_en = 1'b1, cpol = 1'b0, cpha = 1'b0, lsb_first = 1'b0;
    logic interrupt_enable_bit = 1'b1, ctl_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0;
    logic int_clr = 1'b0, rx_ready = 1'b0, ssel_n = 1'b1, ext_sck = 1'b0, ext_mosi = 1'b0, psel = 1'b0;
    logic [7:0] clock_divider_register = 8'h08, data_wdata = 8'h00, ptx = 8'h00;
    logic [7:0] rd_data, status, rx_data, prx, mrx;
    logic interrupt_flag_register, rx_valid, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
    logic [7:0] q[$], eq[$];
    int   err_count = 0, n_compared = 0;
    wire  sck_w = sck_oe ? sck_o : ext_sck;
    wire  mosi_w = mosi_oe ? mosi_o : ext_mosi;
    wire  miso_w = miso_oe ? miso_o : pmiso;

    always #4 clk = ~clk;
    always @(posedge clk) if (rx_valid && rx_ready) q.push_back(rx_data);

    sbc_spi_ctrl uut (.clk, .rst_n, .master_en, .cpol, .cpha, .lsb_first, .interrupt_enable_bit,
        .clock_divider_register, .ctl_wr, .data_wr, .data_wdata, .data_rd, .status_rd, .int_clr, .rd_data,
        .status, .interrupt_flag_register, .rx_valid, .rx_data, .rx_ready, .sck_i(sck_w), .sck_o, .sck_oe,
        .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ssel_n);
    sbc_spi_peer peer (.sck(sck_w), .cpol, .cpha, .lsbf(lsb_first), .sel(psel), .mosi(mosi_w),
        .tx(ptx), .miso(pmiso), .rx(prx));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] b);
        @(negedge clk);
        data_wr = 1'b1;
        data_wdata = b;
        @(negedge clk);
        data_wr = 1'b0;
    endtask : wr
    // Strobe 3 status read, 2 data read, 1 interrupt clear, 0 control write
    task automatic pulse(input int k);
        @(negedge clk);
        {status_rd, data_rd, int_clr, ctl_wr} = 4'h1 << k;
        @(negedge clk);
        {status_rd, data_rd, int_clr, ctl_wr} = 4'h0;
    endtask : pulse
    task automatic wait_done();
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            if (status[7] === 1'b1) return;
        end
        err_count++;
        stop_test();
    endtask : wait_done

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic master_xfer(input logic [3:0] m, input logic [7:0] b, input bit stall);
        @(negedge clk);
        psel = 1'b0;
        {cpol, cpha, lsb_first} = m[2:0];
        clock_divider_register = m[3] ? 8'h0A : 8'h08;
        ptx = ~b;
        eq.push_back(~b);
        repeat (4) @(negedge clk);
        psel = 1'b1;
        wr(b);
        if (stall) begin
            repeat (100) @(negedge clk);
            check(status, 8'h00);
            check({7'h00, sck_o}, {7'h00, cpol});
            rx_ready = 1'b1;
        end
        repeat (20) @(negedge clk);
        wr(8'h5A);
        wait_done();
        @(negedge clk);
        check(status, 8'hC0);
        check(prx, b);
        check(rd_data, ~b);
        check({7'h00, sck_o}, {7'h00, cpol});
        check({7'h00, interrupt_flag_register}, 8'h01);
        pulse(3);
        pulse(2);
        pulse(1);
        check({status[7:6], 5'h00, interrupt_flag_register}, 8'h00);
    endtask : master_xfer
    task automatic ext_xfer(input logic [7:0] b, input int nb);
        @(negedge clk);
        ssel_n = 1'b0;
        mrx = 8'h00;
        repeat (8) @(negedge clk);
        for (int i = 7; i > 7 - nb; i--) begin
            if (!cpha)
                ext_mosi = b[i];
            repeat (8) @(negedge clk);
            ext_sck = ~cpol;
            if (cpha)
                ext_mosi = b[i];
            else
                mrx[i] = miso_w;
            repeat (8) @(negedge clk);
            ext_sck = cpol;
            if (cpha)
                mrx[i] = miso_w;
        end
        repeat (8) @(negedge clk);
        ssel_n = 1'b1;
        ext_mosi = ~ext_mosi;
        repeat (8) @(negedge clk);
    endtask : ext_xfer
    task automatic slave_run();
        @(negedge clk);
        {master_en, cpol, cpha, lsb_first} = 4'h0;
        {psel, interrupt_enable_bit} = 2'h0;
        repeat (4) @(negedge clk);
        wr(8'hA5);
        ext_xfer(8'h3C, 8);
        check(status, 8'h80);
        check(rd_data, 8'h3C);
        check(mrx, 8'hA5);
        check({7'h00, miso_oe}, 8'h00);
        check({7'h00, interrupt_flag_register}, 8'h00);
        ext_xfer(8'hC3, 8);
        check(status, 8'hA0);
        check(rd_data, 8'h3C);
        pulse(3);
        pulse(2);
        ext_xfer(8'h0F, 3);
        check(status, 8'h08);
        pulse(3);
        @(negedge clk);
        {cpol, cpha, lsb_first, ext_sck} = 4'hF;
        wr(8'h0F);
        ext_xfer(8'hC1, 8);
        check(status, 8'h80);
        check(rd_data, 8'h83);
        check(mrx, 8'hF0);
        pulse(3);
        pulse(2);
    endtask : slave_run
    task automatic fault_run();
        @(negedge clk);
        master_en = 1'b1;
        repeat (4) @(negedge clk);
        ssel_n = 1'b0;
        repeat (6) @(negedge clk);
        check(status, 8'h10);
        check({6'h00, sck_oe, mosi_oe}, 8'h00);
        ssel_n = 1'b1;
        pulse(3);
        pulse(0);
        check(status, 8'h00);
    endtask : fault_run

    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        master_xfer(4'h0, 8'h96, 1'b0);
        master_xfer(4'h2, 8'h3C, 1'b0);
        master_xfer(4'hC, 8'hE1, 1'b1);
        master_xfer(4'h7, 8'h4B, 1'b0);
        slave_run();
        fault_run();
        for (int i = 0; i < 4; i++) check(q[i], eq[i]);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
